// ### verilog/monitor_irq_pkg.sv
/*
 * constants for the monitor interrupt status and mask block:
 * register offsets, field positions, reset values and timing.
 * assumes a single 20 MHz core clock.
 */
package monitor_irq_pkg;

    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_FLAGS_A = 8'h41;
    localparam logic [7:0] OFS_FLAGS_B = 8'h42;
    localparam logic [7:0] OFS_BLOCK_A = 8'h43;
    localparam logic [7:0] OFS_BLOCK_B = 8'h44;
    localparam logic [7:0] OFS_SPARE = 8'h45;
    localparam logic [7:0] OFS_CLEAR_CTL = 8'h46;
    localparam logic [7:0] OFS_VOLT_ID = 8'h47;
    localparam logic [7:0] OFS_SLAVE_ADDR = 8'h48;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int BIT_TEMP = 4;
    localparam int BIT_FAN_A = 6;
    localparam int BIT_FAN_B = 7;
    localparam int BIT_RAIL_12V = 0;
    localparam int BIT_NEG_CORE2 = 1;
    localparam int BIT_INTRUSION = 4;
    localparam int BIT_RESET_GATE = 7;
    localparam int BIT_CLEAR_REQ = 7;
    localparam int FAN_A_DIV_LSB = 4;
    localparam int FAN_B_DIV_LSB = 6;

    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RST_FAN_DIV = 2'h1;
    localparam logic [5:0] SLAVE_ADDR_FIXED = 6'h0b;
    localparam logic [1:0] ADDR_LOAD_AT = 2'h3;

    // -------------------------------------------------------------
    // temperature modes
    // -------------------------------------------------------------
    localparam logic [1:0] TEMP_ONE_TIME = 2'h1;
    localparam logic [1:0] TEMP_COMPARATOR = 2'h2;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int CLEAR_PULSE_MS = 20;
    localparam int CLEAR_PULSE_CYCLES = (CLEAR_PULSE_MS * (CLK_HZ / 1000));
    localparam int PULSE_W = 19;

endpackage : monitor_irq_pkg

// ### verilog/monitor_irq_status_mask.sv
/*
 * interrupt status, mask, intrusion clear pulse, voltage id readout with
 * fan divisor select and serial slave address of a system health monitor.
 * assumes the serial protocol engine drives the register port on the same
 * clock, and that comparators give fault levels with a conversion strobe.
 */
// Function
// - voltage faults set status-one bits zero to three
// - temperature fault sets bit four per mode
// - fan faults set status-one bits six, seven
// - 12V and negative/core2 faults set status-two
// - intrusion high sets status-two bit four
// - reading status clears the read flags
// - status read never clears intrusion flag
// - persisting fault raises fresh flag later, except temperature in one-time mode
// - mask bit one blocks matching status bit
// - mask-two bit seven gates remote reset
// - spare register at 0x45 reads/writes
// - clear request drives 20 ms low pulse
// - clear request bit self-clears after pulse
// - voltage id bits follow input pins
// - bits 5:4 choose fan A divisor
// - bits 7:6 choose fan B divisor
// - slave address writable, loads pattern plus pins
// - status, mask, clear registers reset zero
// - two-bit field selects temperature mode
// - interrupt output only while enabled
// - interrupt-clear hides output, pauses monitoring
module monitor_irq_status_mask
    import monitor_irq_pkg::*;
#(
    parameter int PULSE_CYCLES = CLEAR_PULSE_CYCLES
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // monitoring results
    input wire logic conv_done_in,
    input wire logic rail_2v5_fault_in,
    input wire logic core1_rail_fault_in,
    input wire logic rail_3v3_fault_in,
    input wire logic rail_5v_fault_in,
    input wire logic fan_a_fault_in,
    input wire logic fan_b_fault_in,
    input wire logic rail_12v_fault_in,
    input wire logic neg_or_core2_fault_in,
    input wire logic temp_over_hot_in,
    input wire logic temp_below_hyst_in,
    // configuration bits
    input wire logic int_enable_in,
    input wire logic int_clear_in,
    input wire logic reset_request_in,
    input wire logic [1:0] temp_mode_in,
    // pins
    input wire logic intrusion_pin_in,
    output logic intrusion_pin_out,
    output logic intrusion_pin_oe_n_out,
    input wire logic [3:0] cpu_volt_code_in,
    input wire logic addr_select_lo_in,
    input wire logic addr_select_hi_in,
    // outputs
    output logic irq_n_out,
    output logic monitor_paused_out,
    output logic reset_pulse_allowed_out,
    output logic [1:0] fan_a_divisor_out,
    output logic [1:0] fan_b_divisor_out,
    output logic [7:0] bus_slave_address_out
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic [3:0] vid_s1;
        logic [3:0] vid_s2;
        logic [1:0] adr_s1;
        logic [1:0] adr_s2;
        logic [1:0] init_cnt;
        logic [7:0] flags_a;
        logic [7:0] flags_b;
        logic [7:0] block_a;
        logic [7:0] block_b;
        logic [7:0] spare;
        logic [6:0] clear_low;
        logic clear_req;
        logic [PULSE_W-1:0] pulse_cnt;
        logic [1:0] fan_a_div;
        logic [1:0] fan_b_div;
        logic [7:0] slave_addr;
        logic temp_active;
        logic [7:0] rdata;
        logic irq_n;
        logic paused;
        logic reset_gate;
        logic pin_oe_n;
    } state_t;

    state_t st;
    state_t next_st;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // strobe aimed at one register offset
    function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        logic conv;
        logic rd_a;
        logic rd_b;
        logic temp_set;
        logic temp_drop;
        logic [7:0] set_a;
        logic [7:0] set_b;
        logic [7:0] clr_a;
        logic [7:0] clr_b;
        logic wr;
        logic pulse_end;
        logic pending;
        conv = 1'b0;
        rd_a = 1'b0;
        rd_b = 1'b0;
        temp_set = 1'b0;
        temp_drop = 1'b0;
        set_a = 8'h00;
        set_b = 8'h00;
        clr_a = 8'h00;
        clr_b = 8'h00;
        wr = 1'b0;
        pulse_end = 1'b0;
        pending = 1'b0;
        next_st = st;

        // input synchronisers
        next_st.pin_s1 = intrusion_pin_in;
        next_st.pin_s2 = st.pin_s1;
        next_st.vid_s1 = cpu_volt_code_in;
        next_st.vid_s2 = st.vid_s1;
        next_st.adr_s1 = {addr_select_hi_in, addr_select_lo_in};
        next_st.adr_s2 = st.adr_s1;

        conv = conv_done_in && !int_clear_in;
        rd_a = hit(reg_rd_in, reg_addr_in, OFS_FLAGS_A);
        rd_b = hit(reg_rd_in, reg_addr_in, OFS_FLAGS_B);
        pulse_end = st.clear_req && (st.pulse_cnt == PULSE_W'(PULSE_CYCLES - 1));

        // temperature mode handling
        unique case (temp_mode_in)
            TEMP_ONE_TIME: begin
                temp_set = conv && temp_over_hot_in && !st.temp_active;
                if (conv && temp_over_hot_in) begin
                    next_st.temp_active = 1'b1;
                end else if (conv && temp_below_hyst_in) begin
                    next_st.temp_active = 1'b0;
                end
            end
            TEMP_COMPARATOR: begin
                temp_set = conv && temp_over_hot_in;
                temp_drop = conv && !temp_over_hot_in;
                next_st.temp_active = 1'b0;
            end
            default: begin
                if (conv && temp_over_hot_in) begin
                    next_st.temp_active = 1'b1;
                end else if (conv && temp_below_hyst_in) begin
                    next_st.temp_active = 1'b0;
                end
                temp_set = conv && (temp_over_hot_in || (st.temp_active && !temp_below_hyst_in));
            end
        endcase

        // fault inputs sampled each conversion, intrusion every cycle; a lasting fault re-sets later except one-time temperature
        set_a[0] = conv && rail_2v5_fault_in;
        set_a[1] = conv && core1_rail_fault_in;
        set_a[2] = conv && rail_3v3_fault_in;
        set_a[3] = conv && rail_5v_fault_in;
        set_a[BIT_TEMP] = temp_set;
        set_a[BIT_FAN_A] = conv && fan_a_fault_in;
        set_a[BIT_FAN_B] = conv && fan_b_fault_in;
        set_b[BIT_RAIL_12V] = conv && rail_12v_fault_in;
        set_b[BIT_NEG_CORE2] = conv && neg_or_core2_fault_in;
        set_b[BIT_INTRUSION] = st.pin_s2 && !st.clear_req;

        // read clears, set wins
        clr_a = rd_a ? 8'hff : 8'h00;
        clr_a[BIT_TEMP] = clr_a[BIT_TEMP] || temp_drop;
        clr_b = rd_b ? 8'hef : 8'h00;
        clr_b[BIT_INTRUSION] = pulse_end;
        next_st.flags_a = ((st.flags_a & ~clr_a) | set_a) & 8'hdf;
        next_st.flags_b = ((st.flags_b & ~clr_b) | set_b) & 8'h13;

        // register writes
        wr = reg_wr_in;
        if (hit(wr, reg_addr_in, OFS_BLOCK_A)) begin
            next_st.block_a = reg_wdata_in;
        end
        if (hit(wr, reg_addr_in, OFS_BLOCK_B)) begin
            next_st.block_b = reg_wdata_in;
        end
        if (hit(wr, reg_addr_in, OFS_SPARE)) begin
            next_st.spare = reg_wdata_in;
        end
        if (hit(wr, reg_addr_in, OFS_CLEAR_CTL)) begin
            next_st.clear_low = reg_wdata_in[6:0];
            if (!st.clear_req && reg_wdata_in[BIT_CLEAR_REQ]) begin
                next_st.clear_req = 1'b1;
                next_st.pulse_cnt = '0;
            end
        end
        if (hit(wr, reg_addr_in, OFS_VOLT_ID)) begin
            next_st.fan_a_div = reg_wdata_in[FAN_A_DIV_LSB +: 2];
            next_st.fan_b_div = reg_wdata_in[FAN_B_DIV_LSB +: 2];
        end

        // address strap caught once both synchroniser stages hold the pins
        if (st.init_cnt != ADDR_LOAD_AT) begin
            next_st.init_cnt = st.init_cnt + 2'h1;
            if (st.init_cnt + 2'h1 == ADDR_LOAD_AT) begin
                next_st.slave_addr = {SLAVE_ADDR_FIXED, st.adr_s2};
            end
        end else if (hit(wr, reg_addr_in, OFS_SLAVE_ADDR)) begin
            next_st.slave_addr = reg_wdata_in;
        end

        // intrusion clear pulse
        if (st.clear_req) begin
            if (pulse_end) begin
                next_st.clear_req = 1'b0;
            end else begin
                next_st.pulse_cnt = st.pulse_cnt + 1'b1;
            end
        end
        next_st.pin_oe_n = !next_st.clear_req;

        // read data
        unique case (reg_addr_in)
            OFS_FLAGS_A: next_st.rdata = st.flags_a;
            OFS_FLAGS_B: next_st.rdata = st.flags_b;
            OFS_BLOCK_A: next_st.rdata = st.block_a;
            OFS_BLOCK_B: next_st.rdata = st.block_b;
            OFS_SPARE: next_st.rdata = st.spare;
            OFS_CLEAR_CTL: next_st.rdata = {st.clear_req, st.clear_low};
            OFS_VOLT_ID: next_st.rdata = {st.fan_b_div, st.fan_a_div, st.vid_s2};
            OFS_SLAVE_ADDR: next_st.rdata = st.slave_addr;
            default: next_st.rdata = 8'h00;
        endcase
        if (!reg_rd_in) begin
            next_st.rdata = st.rdata;
        end

        // interrupt and gates
        pending = |(st.flags_a & ~st.block_a) || |(st.flags_b & ~st.block_b);
        next_st.irq_n = !(int_enable_in && !int_clear_in && pending);
        next_st.paused = int_clear_in;
        next_st.reset_gate = reset_request_in && st.block_b[BIT_RESET_GATE];
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st <= '0;
            st.irq_n <= 1'b1;
            st.pin_oe_n <= 1'b1;
            st.fan_a_div <= RST_FAN_DIV;
            st.fan_b_div <= RST_FAN_DIV;
            st.slave_addr <= {SLAVE_ADDR_FIXED, 2'h0};
            st.flags_a <= RST_REG;
            st.flags_b <= RST_REG;
        end else begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign reg_rdata_out = st.rdata;
    assign irq_n_out = st.irq_n;
    assign monitor_paused_out = st.paused;
    assign reset_pulse_allowed_out = st.reset_gate;
    assign intrusion_pin_out = 1'b0;
    assign intrusion_pin_oe_n_out = st.pin_oe_n;
    assign fan_a_divisor_out = st.fan_a_div;
    assign fan_b_divisor_out = st.fan_b_div;
    assign bus_slave_address_out = st.slave_addr;

endmodule // monitor_irq_status_mask

// ### dv/monitor_irq_sva.sv
/*
 * port checks of the monitor interrupt block.
 * assumes one clock domain; the bind hands on PULSE_CYCLES.
 */
module monitor_irq_sva
    import monitor_irq_pkg::*;
#(
    parameter int PULSE_CYCLES = CLEAR_PULSE_CYCLES
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    // control and outputs
    input wire logic conv_done_in,
    input wire logic int_enable_in,
    input wire logic int_clear_in,
    input wire logic reset_request_in,
    input wire logic intrusion_pin_oe_n_out,
    input wire logic irq_n_out,
    input wire logic reset_pulse_allowed_out,
    input wire logic [1:0] fan_a_divisor_out,
    input wire logic [1:0] fan_b_divisor_out,
    input wire logic [7:0] bus_slave_address_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    int low_cnt;
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= intrusion_pin_oe_n_out ? 0 : low_cnt + 1;
        end
    end
    // -------------------------------------------------------------
    // sequences and assertions
    // -------------------------------------------------------------
    sequence clear_write;
        reg_wr_in && reg_addr_in == OFS_CLEAR_CTL && reg_wdata_in[BIT_CLEAR_REQ];
    endsequence
    sequence read_a;
        reg_rd_in && reg_addr_in == OFS_FLAGS_A && !conv_done_in;
    endsequence
    sequence addr_write(logic [7:0] ofs);
        reg_wr_in && reg_addr_in == ofs ##1 !reg_wr_in;
    endsequence
    a_pulse_start: assert property (clear_write ##0 intrusion_pin_oe_n_out |=> !intrusion_pin_oe_n_out)
        else $error("clear write did not start pulse");
    a_pulse_width: assert property ($rose(intrusion_pin_oe_n_out) |-> low_cnt == PULSE_CYCLES)
        else $error("clear pulse length wrong");
    a_read_clears: assert property (!conv_done_in ##1 read_a ##1 !conv_done_in ##1 read_a |=>
        reg_rdata_out == 8'h00)
        else $error("read did not clear flags");
    a_irq_disabled: assert property (!int_enable_in |=> irq_n_out)
        else $error("irq while disabled");
    a_irq_cleared: assert property (int_clear_in |=> irq_n_out)
        else $error("irq while clear bit set");
    a_reserved_a: assert property (reg_rd_in && reg_addr_in == OFS_FLAGS_A |=> !reg_rdata_out[5])
        else $error("reserved flag bit set");
    a_reserved_b: assert property (reg_rd_in && reg_addr_in == OFS_FLAGS_B |=>
        (reg_rdata_out & 8'hec) == 8'h00)
        else $error("reserved flag bit set");
    a_gate_request: assert property (!reset_request_in |=> !reset_pulse_allowed_out)
        else $error("reset gate open without request");
    a_gate_mask: assert property (reg_wr_in && reg_addr_in == OFS_BLOCK_B && !reg_wdata_in[BIT_RESET_GATE]
        ##1 !(reg_wr_in && reg_addr_in == OFS_BLOCK_B) |=> !reset_pulse_allowed_out)
        else $error("reset gate open without mask bit");
    a_divisor_write: assert property (addr_write(OFS_VOLT_ID) |=>
        fan_a_divisor_out == $past(reg_wdata_in[5:4], 2) && fan_b_divisor_out == $past(reg_wdata_in[7:6], 2))
        else $error("fan divisor not taken");
    a_address_write: assert property (addr_write(OFS_SLAVE_ADDR) |=>
        bus_slave_address_out == $past(reg_wdata_in, 2))
        else $error("slave address not taken");
endmodule // monitor_irq_sva

bind monitor_irq_status_mask monitor_irq_sva #(.PULSE_CYCLES(PULSE_CYCLES)) sva_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .conv_done_in(conv_done_in),
    .int_enable_in(int_enable_in), .int_clear_in(int_clear_in), .reset_request_in(reset_request_in),
    .intrusion_pin_oe_n_out(intrusion_pin_oe_n_out), .irq_n_out(irq_n_out),
    .reset_pulse_allowed_out(reset_pulse_allowed_out), .fan_a_divisor_out(fan_a_divisor_out),
    .fan_b_divisor_out(fan_b_divisor_out), .bus_slave_address_out(bus_slave_address_out)
);

// ### dv/intrusion_line.sv
/*
 * open-drain intrusion line with the lid switch as the far side.
 * assumes the device pulls low only while its enable is low.
 */
module intrusion_line (
    // lid switch and device drive
    input wire logic lid_open_in,
    input wire logic drive_val_in,
    input wire logic drive_oe_n_in,
    // resolved level
    output logic level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign level_out = drive_oe_n_in ? lid_open_in : drive_val_in;
endmodule // intrusion_line

// ### dv/test_monitor_irq_status_mask.sv
/*
 * bench for the monitor interrupt block: register tasks and directed tests.
 * assumes PULSE_CYCLES of 8 and the intrusion line model.
 */
module test_monitor_irq_status_mask;
    import monitor_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic conv = 1'b0;
    logic hot = 1'b0;
    logic hyst = 1'b1;
    logic int_en = 1'b0;
    logic int_clr = 1'b0;
    logic rst_req = 1'b0;
    logic lid = 1'b0;
    logic [1:0] tmode = 2'h0;
    logic [3:0] cpu_volt_code = 4'ha;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] flt = 8'h00;
    logic [7:0] rdata, slave;
    logic [1:0] div_a, div_b;
    logic pin_lvl, pin_val, oe_n, irq_n, paused, gate;
    int error_cnt = 0;
    int comparisons = 0;
    int waited = 0;
    monitor_irq_status_mask #(.PULSE_CYCLES(8)) dut (
        .core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .conv_done_in(conv), .rail_2v5_fault_in(flt[0]),
        .core1_rail_fault_in(flt[1]), .rail_3v3_fault_in(flt[2]), .rail_5v_fault_in(flt[3]),
        .fan_a_fault_in(flt[4]), .fan_b_fault_in(flt[5]), .rail_12v_fault_in(flt[6]),
        .neg_or_core2_fault_in(flt[7]), .temp_over_hot_in(hot), .temp_below_hyst_in(hyst),
        .int_enable_in(int_en), .int_clear_in(int_clr), .reset_request_in(rst_req), .temp_mode_in(tmode),
        .intrusion_pin_in(pin_lvl), .intrusion_pin_out(pin_val), .intrusion_pin_oe_n_out(oe_n),
        .cpu_volt_code_in(cpu_volt_code), .addr_select_lo_in(1'b0), .addr_select_hi_in(1'b1), .irq_n_out(irq_n),
        .monitor_paused_out(paused), .reset_pulse_allowed_out(gate), .fan_a_divisor_out(div_a),
        .fan_b_divisor_out(div_b), .bus_slave_address_out(slave)
    );
    intrusion_line lid_i (.lid_open_in(lid), .drive_val_in(pin_val), .drive_oe_n_in(oe_n), .level_out(pin_lvl));
    initial begin
        forever #25 clk = ~clk;
    end
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic run_conv;
        @(posedge clk);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd_reg(8'h40 + 8'(i), (i == 7) ? 8'h5a : (i == 8) ? 8'h2e : 8'h00);
        end
        wr_reg(OFS_SPARE, 8'ha5);
        rd_reg(OFS_SPARE, 8'ha5);
        wr_reg(OFS_BLOCK_A, 8'hff);
        rd_reg(OFS_BLOCK_A, 8'hff);
        wr_reg(OFS_BLOCK_B, 8'h13);
        $display("test registers done");
        @(posedge clk);
        flt <= 8'hff;
        int_en <= 1'b1;
        run_conv;
        settle;
        chk({7'h00, irq_n}, 8'h01);
        wr_reg(OFS_BLOCK_A, 8'h00);
        wr_reg(OFS_BLOCK_B, 8'h00);
        settle;
        chk({7'h00, irq_n}, 8'h00);
        int_clr <= 1'b1;
        settle;
        chk({6'h00, paused, irq_n}, 8'h03);
        int_clr <= 1'b0;
        int_en <= 1'b0;
        settle;
        chk({7'h00, irq_n}, 8'h01);
        int_en <= 1'b1;
        rd_reg(OFS_FLAGS_A, 8'hcf);
        rd_reg(OFS_FLAGS_A, 8'h00);
        rd_reg(OFS_FLAGS_B, 8'h03);
        settle;
        chk({7'h00, irq_n}, 8'h01);
        run_conv;
        rd_reg(OFS_FLAGS_A, 8'hcf);
        rd_reg(OFS_FLAGS_B, 8'h03);
        flt <= 8'h00;
        $display("test faults done");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            tmode <= 2'(m);
            hot <= 1'b1;
            hyst <= 1'b0;
            run_conv;
            rd_reg(OFS_FLAGS_A, 8'h10);
            run_conv;
            rd_reg(OFS_FLAGS_A, (m == 1) ? 8'h00 : 8'h10);
            @(posedge clk);
            hot <= 1'b0;
            hyst <= 1'b1;
            run_conv;
            rd_reg(OFS_FLAGS_A, 8'h00);
        end
        $display("test temperature done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_VOLT_ID, {2'(i), 2'(3 - i), 4'h0});
            rd_reg(OFS_VOLT_ID, {2'(i), 2'(3 - i), cpu_volt_code});
            chk({2'(i), 2'(3 - i), 4'h0}, {div_b, div_a, 4'h0});
        end
        rst_req <= 1'b1;
        wr_reg(OFS_BLOCK_B, 8'h80);
        settle;
        chk({7'h00, gate}, 8'h01);
        wr_reg(OFS_BLOCK_B, 8'h00);
        settle;
        chk({7'h00, gate}, 8'h00);
        wr_reg(OFS_SLAVE_ADDR, 8'h5a);
        rd_reg(OFS_SLAVE_ADDR, 8'h5a);
        chk(slave, 8'h5a);
        $display("test fields done");
        lid <= 1'b1;
        settle;
        rd_reg(OFS_FLAGS_B, 8'h10);
        lid <= 1'b0;
        settle;
        rd_reg(OFS_FLAGS_B, 8'h10);
        chk({7'h00, irq_n}, 8'h00);
        wr_reg(OFS_CLEAR_CTL, 8'h80);
        #1;
        chk({6'h00, oe_n, pin_val}, 8'h00);
        rd_reg(OFS_CLEAR_CTL, 8'h80);
        wr_reg(OFS_CLEAR_CTL, 8'h80);
        // pulse of 8 began four edges before the second request
        while (waited < 40 && oe_n !== 1'b1) begin
            @(posedge clk);
            #1;
            waited++;
        end
        chk(8'(waited), 8'h04);
        rd_reg(OFS_CLEAR_CTL, 8'h00);
        rd_reg(OFS_FLAGS_B, 8'h00);
        $display("test intrusion done");
        tally_and_finish();
    end
    initial begin
        #200_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // test_monitor_irq_status_mask
